// file: rtl/dmr_fifo.sv
// Flip-flop FIFO with valid and ready on both sides.
`default_nettype none
module dmr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Filling side
  dmr_stream_if.snk wr,
  // Draining side
  dmr_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count.
  assign wr.ready = (cnt != (AW+1)'(DEPTH));
  assign rd.valid = (cnt != '0);
  assign rd.data = mem[rp];
  assign push = wr.valid && wr.ready;
  assign pop = rd.valid && rd.ready;

  // Storage is written only on an accepted word.
  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wp] <= wr.data;
  end

  // Pointers and count move together so full and empty stay honest.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end
    else
    begin
      if (push)
        wp <= wp + AW'(1);
      if (pop)
        rp <= rp + AW'(1);
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// file: rtl/dmr_mode_regs.sv
// Mode register decode and the read, write and termination behaviour it sets.
// How it works
// - CAS latency comes from mode 0 bits A2 and A6..A4, whole cycles.
// - First read beat appears additive plus CAS latency after the command if eight words are buffered by then.
// - Mode 0 bit A3 picks sequential (0) or interleaved (1) order.
// - Mode 0 A1..A0 pick fixed chop, fixed eight, or per-command via A12.
// - Reads start at CA[2:0]; sequential wraps in fours, interleave XORs.
// - Chopped reads drive four beats, drivers off for the other four.
// - Writes ignore low column bits; chop uses CA2 to pick a half.
// - Fixed-chop writes start internally two clocks before eight-beat ones.
// - DLL reset bit clears itself once the reset has been issued.
// - Mode 0 A11..A9 hold write recovery; controller programs enough.
// - Mode 0 A12 low freezes DLL in precharge power-down; high keeps it.
// - Enabled DLL turns off in self-refresh and back on at exit.
// - Driver impedance comes from mode 1 bits A5 and A1.
// - Write termination applies in writes even with nominal off.
// - Writes do not need the DLL unless write termination is on.
// - Mode 1 A12 high turns every data and strobe driver off.
// - Reads and writes wait the additive latency before running inside.
`default_nettype none
module dmr_mode_regs (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Command and address bus
  input wire logic cke,
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic [2:0] ba,
  input wire logic [dmr_pkg::ADDR_W-1:0] addr,
  // Power states and termination pin
  input wire logic selfRefresh,
  input wire logic prechargePd,
  input wire logic odt,
  // Array read words, eight per burst in column order
  input wire logic arrValid,
  input wire logic [dmr_pkg::DQ_W-1:0] arrData,
  output logic arrReady,
  // Data and strobe drivers
  output logic [dmr_pkg::DQ_W-1:0] dqOut,
  output logic dqOeN,
  output logic dqsOut,
  output logic dqsOeN,
  // Internal write
  output logic intWrite,
  output logic [dmr_pkg::BEATS-1:0] wrBeatMask,
  // Decoded settings and status
  output logic [4:0] casLatency,
  output logic [4:0] addLatency,
  output logic [4:0] readLatency,
  output logic [4:0] wrRecovery,
  output logic [1:0] drvImpedance,
  output logic [2:0] rttNom,
  output logic [1:0] rttWr,
  output logic termSelWr,
  output logic termNeedsDll,
  output logic dllOn,
  output logic dllResetPulse,
  output logic slowExit,
  output logic testMode,
  output logic writeLevel
);
  import dmr_pkg::*;

  logic [ADDR_W-1:0] mr0;
  logic [ADDR_W-1:0] mr1;
  logic [ADDR_W-1:0] mr2;
  logic cmdSel;
  logic mrsCmd;
  logic rdCmd;
  logic wrCmd;
  logic cmdChop;
  logic [4:0] cwl;
  logic [4:0] wrBase;
  dmr_rd_t rdState;
  logic [4:0] rdCount;
  logic [2:0] rdStart;
  logic rdChop;
  logic rdInter;
  logic [2:0] rdBeat;
  logic [3:0] fillIdx;
  logic [DQ_W-1:0] burstBuf [BEATS];
  logic bufFull;
  logic bufLoad;
  logic fire;
  logic [2:0] nextBeat;
  logic wrPend;
  logic [4:0] wrCount;
  logic wrFix4;

  dmr_stream_if #(.W(DQ_W)) inIf ();
  dmr_stream_if #(.W(DQ_W)) outIf ();

  // Burst beat index for a start column and beat number.
  function automatic logic [2:0] beatOrder(input logic [2:0] s,
    input logic [2:0] i, input logic inter);
    logic [2:0] r;
    r = {s[2] ^ i[2], s[1:0] + i[1:0]};
    if (inter)
      r = s ^ i;
    return r;
  endfunction

  // Commands are taken only with the clock enabled and the chip selected.
  assign cmdSel = cke && !csN;
  assign mrsCmd = cmdSel && !rasN && !casN && !weN;
  assign rdCmd = cmdSel && rasN && !casN && weN;
  assign wrCmd = cmdSel && rasN && !casN && !weN;
  // Chop is fixed or chosen per command by the burst-chop pin when low.
  assign cmdChop = (mr0[MR0_BL+:2] == BL_FIX4) ||
    ((mr0[MR0_BL+:2] == BL_OTF) && !addr[BC_PIN]);

  // Mode registers load on a set command addressed by the bank bits.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      mr0 <= MR_RESET;
      mr1 <= MR_RESET;
      mr2 <= MR_RESET;
    end
    else
    begin
      if (mrsCmd && ba == BA_MR0)
        mr0 <= addr;
      else if (mr0[MR0_DLLRST])
        mr0[MR0_DLLRST] <= 1'b0;
      if (mrsCmd && ba == BA_MR1)
        mr1 <= addr;
      if (mrsCmd && ba == BA_MR2)
        mr2 <= addr;
    end
  end

  // Latency and recovery decode with the standard field encodings.
  always_comb
  begin
    casLatency = (mr0[MR0_CLL] ? CL_BASE_HI : CL_BASE_LO) +
      {2'h0, mr0[MR0_CLH+:3]};
    unique case (mr1[MR1_AL+:2])
      2'h1: addLatency = casLatency - 5'h01;
      2'h2: addLatency = casLatency - 5'h02;
      default: addLatency = 5'h00;
    endcase
    unique case (mr0[MR0_WR+:3])
      3'h0: wrRecovery = 5'h10;
      3'h1: wrRecovery = 5'h05;
      3'h2: wrRecovery = 5'h06;
      3'h3: wrRecovery = 5'h07;
      3'h4: wrRecovery = 5'h08;
      3'h5: wrRecovery = 5'h0a;
      3'h6: wrRecovery = 5'h0c;
      default: wrRecovery = 5'h0e;
    endcase
  end
  assign readLatency = addLatency + casLatency;
  assign cwl = CWL_BASE + {2'h0, mr2[MR2_CWL+:3]};
  assign wrBase = addLatency + cwl + WR_INT_OFFSET;

  // Static settings that steer drivers, termination and power-down.
  assign drvImpedance = {mr1[MR1_DIC1], mr1[MR1_DIC0]};
  assign rttNom = {mr1[MR1_RTT2], mr1[MR1_RTT1], mr1[MR1_RTT0]};
  assign rttWr = mr2[MR2_RTTWR+:2];
  assign slowExit = !mr0[MR0_PPD];
  assign testMode = mr0[MR0_TM];
  assign writeLevel = mr1[MR1_WLVL];
  assign dllResetPulse = mr0[MR0_DLLRST];
  // The DLL stops in self-refresh and in slow-exit precharge power-down.
  assign dllOn = !mr1[MR1_DLLDIS] && !selfRefresh &&
    !(prechargePd && slowExit);
  // Write termination replaces nominal during writes when programmed.
  assign termSelWr = wrPend && odt && (rttWr != 2'h0);
  // Writes run without the DLL; only write termination relies on it.
  assign termNeedsDll = termSelWr && !dllOn;

  // The array feeds the FIFO; the FIFO feeds the burst buffer.
  assign inIf.valid = arrValid;
  assign inIf.data = arrData;
  assign arrReady = inIf.ready;
  assign bufFull = (fillIdx == 4'h8);
  assign bufLoad = !bufFull && (rdState != RD_BURST);
  assign outIf.ready = bufLoad;

  dmr_fifo #(.WIDTH(DQ_W), .DEPTH(FIFO_DEPTH)) readFifo (
    .mclk(mclk),
    .resetn(resetn),
    .wr(inIf),
    .rd(outIf)
  );

  // Each buffer entry takes the word whose column matches its index.
  for (genvar g = 0; g < BEATS; g++)
  begin : g_buf
    always_ff @(posedge mclk)
    begin
      if (bufLoad && outIf.valid && fillIdx[2:0] == 3'(g))
        burstBuf[g] <= outIf.data;
    end
  end

  // Buffer fill level; it empties when a burst is finished.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      fillIdx <= 4'h0;
    else if (rdState == RD_BURST && rdBeat == 3'h7)
      fillIdx <= 4'h0;
    else if (bufLoad && outIf.valid)
      fillIdx <= fillIdx + 4'h1;
  end

  assign fire = (rdState == RD_WAIT) && (rdCount == 5'h01) && bufFull;
  assign nextBeat = rdBeat + 3'h1;

  // Read sequencer: latency count, then eight beat slots.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdState <= RD_IDLE;
      rdCount <= 5'h00;
      rdStart <= 3'h0;
      rdChop <= 1'b0;
      rdInter <= 1'b0;
      rdBeat <= 3'h0;
    end
    else
    begin
      unique case (rdState)
        RD_IDLE:
          if (rdCmd)
          begin
            rdState <= RD_WAIT;
            rdCount <= readLatency;
            rdStart <= addr[2:0];
            rdChop <= cmdChop;
            rdInter <= mr0[MR0_BT];
          end
        RD_WAIT:
          if (fire)
          begin
            rdState <= RD_BURST;
            rdBeat <= 3'h0;
          end
          else if (rdCount > 5'h01)
            rdCount <= rdCount - 5'h01;
        RD_BURST:
          if (rdBeat == 3'h7)
            rdState <= RD_IDLE;
          else
            rdBeat <= nextBeat;
      endcase
    end
  end

  // Data and strobe drivers, registered one beat per clock.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      dqOut <= '0;
      dqOeN <= 1'b1;
      dqsOut <= 1'b0;
    end
    else if (fire)
    begin
      dqOut <= burstBuf[beatOrder(rdStart, 3'h0, rdInter)];
      dqOeN <= mr1[MR1_QOFF];
      dqsOut <= 1'b1;
    end
    else if (rdState == RD_BURST && rdBeat != 3'h7)
    begin
      dqOut <= burstBuf[beatOrder(rdStart, nextBeat, rdInter)];
      dqOeN <= mr1[MR1_QOFF] || (rdChop && nextBeat[2]);
      dqsOut <= !nextBeat[0];
    end
    else
    begin
      dqOeN <= 1'b1;
      dqsOut <= 1'b0;
    end
  end
  assign dqsOeN = dqOeN;

  // Write timing: one write outstanding, internal start after its count.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      wrPend <= 1'b0;
      wrCount <= 5'h00;
      wrFix4 <= 1'b0;
      wrBeatMask <= '0;
      intWrite <= 1'b0;
    end
    else
    begin
      intWrite <= 1'b0;
      if (!wrPend && wrCmd)
      begin
        wrPend <= 1'b1;
        wrFix4 <= (mr0[MR0_BL+:2] == BL_FIX4);
        wrCount <= (mr0[MR0_BL+:2] == BL_FIX4) ?
          wrBase - WR_CHOP_PULLIN : wrBase;
        wrBeatMask <= !cmdChop ? 8'hff :
          (addr[2] ? 8'hf0 : 8'h0f);
      end
      else if (wrPend)
      begin
        if (wrCount == 5'h01)
        begin
          wrPend <= 1'b0;
          intWrite <= 1'b1;
        end
        else
          wrCount <= wrCount - 5'h01;
      end
    end
  end

  // Helper counters that measure elapsed cycles for the checks below.
  logic [5:0] rdAge;
  logic [5:0] wrAge;
  logic [4:0] rdLatHeld;
  logic [4:0] wrBaseHeld;
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdAge <= 6'h00;
      wrAge <= 6'h00;
      rdLatHeld <= 5'h00;
      wrBaseHeld <= 5'h00;
    end
    else
    begin
      rdAge <= (rdState == RD_IDLE && rdCmd) ? 6'h00 : rdAge + 6'h01;
      wrAge <= (!wrPend && wrCmd) ? 6'h00 : wrAge + 6'h01;
      if (rdState == RD_IDLE && rdCmd)
        rdLatHeld <= readLatency;
      if (!wrPend && wrCmd)
        wrBaseHeld <= wrBase;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  sequence burstBegin;
    rdState == RD_WAIT && rdCount == 5'h01 && bufFull;
  endsequence

  a_dll_rst_clear:
    assert property ((mr0[MR0_DLLRST] && !(mrsCmd && ba == BA_MR0))
      |=> !mr0[MR0_DLLRST])
    else $error("DLL reset bit did not clear itself.");
  a_cl_decode:
    assert property ((mrsCmd && ba == BA_MR0 && addr[6:4] == 3'h0 &&
      addr[2]) |=> casLatency == 5'h0c)
    else $error("CAS latency decode is wrong.");
  a_read_latency:
    assert property (burstBegin and (rdAge == 6'(rdLatHeld - 5'h01))
      |=> !dqOeN || mr1[MR1_QOFF])
    else $error("First read beat not at the read latency.");
  a_first_beat:
    assert property (burstBegin |=> dqOut == burstBuf[rdStart])
    else $error("Read burst did not start at the start column.");
  a_seq_wrap:
    assert property ((rdState == RD_BURST && rdBeat == 3'h4 && !rdInter)
      |-> dqOut == burstBuf[rdStart ^ 3'h4])
    else $error("Sequential burst did not move to the other half.");
  a_interleave:
    assert property ((rdState == RD_BURST && rdInter)
      |-> dqOut == burstBuf[rdStart ^ rdBeat])
    else $error("Interleaved beat order is wrong.");
  a_chop_hiz:
    assert property ((rdState == RD_BURST && rdChop && rdBeat == 3'h3)
      |=> dqOeN [*4])
    else $error("Chopped read drove beyond four beats.");
  a_qoff:
    assert property ((mr1[MR1_QOFF] && $past(mr1[MR1_QOFF])) |-> dqOeN)
    else $error("Drivers enabled while outputs are off.");
  a_wr_mask:
    assert property ((!wrPend && wrCmd && cmdChop) |=>
      wrBeatMask == ($past(addr[2]) ? 8'hf0 : 8'h0f))
    else $error("Chopped write picked the wrong half.");
  a_chop_pullin:
    assert property (intWrite |-> wrAge ==
      6'(wrFix4 ? wrBaseHeld - 5'h02 : wrBaseHeld))
    else $error("Internal write start time is wrong.");
  a_dll_selfref:
    assert property (selfRefresh |-> !dllOn)
    else $error("DLL still on in self-refresh.");
endmodule
`default_nettype wire

// file: rtl/dmr_pkg.sv
// Package of field positions, encodings and timing counts for the mode logic.
`default_nettype none
package dmr_pkg;
  localparam int ADDR_W = 16;
  localparam int DQ_W = 16;
  localparam int BEATS = 8;
  localparam int FIFO_DEPTH = 16;
  // Bank address codes that select a mode register.
  localparam logic [2:0] BA_MR0 = 3'h0;
  localparam logic [2:0] BA_MR1 = 3'h1;
  localparam logic [2:0] BA_MR2 = 3'h2;
  // Mode register 0 field positions.
  localparam int MR0_BL = 0;
  localparam int MR0_CLL = 2;
  localparam int MR0_BT = 3;
  localparam int MR0_CLH = 4;
  localparam int MR0_TM = 7;
  localparam int MR0_DLLRST = 8;
  localparam int MR0_WR = 9;
  localparam int MR0_PPD = 12;
  // Mode register 1 field positions.
  localparam int MR1_DLLDIS = 0;
  localparam int MR1_DIC0 = 1;
  localparam int MR1_RTT0 = 2;
  localparam int MR1_AL = 3;
  localparam int MR1_DIC1 = 5;
  localparam int MR1_RTT1 = 6;
  localparam int MR1_WLVL = 7;
  localparam int MR1_RTT2 = 9;
  localparam int MR1_QOFF = 12;
  // Mode register 2 field positions and the burst-chop address pin.
  localparam int MR2_CWL = 3;
  localparam int MR2_RTTWR = 9;
  localparam int BC_PIN = 12;
  // Burst length codes.
  localparam logic [1:0] BL_FIX8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIX4 = 2'h2;
  // Reset values; mode contents are all zero until written.
  localparam logic [ADDR_W-1:0] MR_RESET = 16'h0000;
  // Latency bases and write timing counts, in clock cycles.
  localparam logic [4:0] CL_BASE_LO = 5'h04;
  localparam logic [4:0] CL_BASE_HI = 5'h0c;
  localparam logic [4:0] CWL_BASE = 5'h05;
  localparam logic [4:0] WR_INT_OFFSET = 5'h04;
  localparam logic [4:0] WR_CHOP_PULLIN = 5'h02;
  typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_BURST} dmr_rd_t;
endpackage
`default_nettype wire

// file: rtl/dmr_stream_if.sv
// Interface carrying one valid/ready word stream between design modules.
`default_nettype none
interface dmr_stream_if #(parameter int W = 16);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// file: verification/ddr3_mode_register_fields_tb.sv
// Self-checking bench for the mode register decode block.
`default_nettype none
module ddr3_mode_register_fields_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic cke = 1'b1;
  logic csN = 1'b1;
  logic rasN = 1'b1;
  logic casN = 1'b1;
  logic weN = 1'b1;
  logic [2:0] ba = 3'h0;
  logic [15:0] addr = 16'h0000;
  logic selfRefresh = 1'b0;
  logic prechargePd = 1'b0;
  logic odt = 1'b0;
  logic pause = 1'b0;
  logic qo = 1'b0;
  logic tw = 1'b0;
  logic arrValid, arrReady, dqOeN, dqsOut, dqsOeN, intWrite;
  logic [15:0] arrData, dqOut;
  logic [7:0] wrBeatMask;
  logic [4:0] casLatency, addLatency, readLatency, wrRecovery;
  logic [1:0] drvImpedance, rttWr;
  logic [2:0] rttNom;
  logic termSelWr, termNeedsDll, dllOn, dllResetPulse, slowExit;
  logic testMode, writeLevel;
  logic [12:0] burst = 13'h0000;
  int rl = 0;
  int waitN = 0;
  int miscompares = 0;
  int samplesChecked = 0;
  // Wait after a DLL reset before any read; the length is a plain default.
  localparam int DLL_LOCK_CYCLES = 600;

  // Clock at 250 MHz.
  always #2 mclk = ~mclk;

  dmr_array_model src (.mclk, .resetn, .pause, .arrValid, .arrData,
    .arrReady);
  dmr_mode_regs dut (.mclk, .resetn, .cke, .csN, .rasN, .casN, .weN, .ba,
    .addr, .selfRefresh, .prechargePd, .odt, .arrValid, .arrData,
    .arrReady, .dqOut, .dqOeN, .dqsOut, .dqsOeN, .intWrite, .wrBeatMask,
    .casLatency, .addLatency, .readLatency, .wrRecovery, .drvImpedance,
    .rttNom, .rttWr, .termSelWr, .termNeedsDll, .dllOn, .dllResetPulse,
    .slowExit, .testMode, .writeLevel);

  // Prints the counts and the verdict, then stops the run.
  task automatic finalReport();
    $display("Checked %0d, mismatched %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samplesChecked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Drives one command for a single edge, then returns to no-operation.
  task automatic cmd(input logic r, input logic c, input logic w,
    input logic [2:0] b, input logic [15:0] a);
    @(posedge mclk);
    #1;
    {csN, rasN, casN, weN, ba, addr} = {1'b0, r, c, w, b, a};
    @(posedge mclk);
    #1;
    {csN, rasN, casN, weN} = 4'hf;
  endtask

  task automatic mrs(input logic [2:0] b, input logic [15:0] a);
    cmd(1'b0, 1'b0, 1'b0, b, a);
  endtask

  // Reads one burst and checks every beat slot against the order tables.
  task automatic rd(input logic [2:0] ca, input logic chop,
    input logic inter, input logic late);
    logic [2:0] c;
    cmd(1'b1, 1'b0, 1'b1, 3'h0, {3'h0, ~chop, 9'h000, ca});
    waitN = 0;
    if (!late)
      repeat (rl - 1) @(posedge mclk);
    while (late && dqOeN !== 1'b0 && waitN < 80)
    begin
      @(posedge mclk);
      #1;
      waitN++;
    end
    if (waitN >= 80)
    begin
      miscompares++;
      finalReport();
    end
    for (int b = 0; b < 8; b++)
    begin
      if (b > 0 || !late)
      begin
        @(posedge mclk);
        #1;
      end
      c = inter ? ca ^ b[2:0] : {ca[2] ^ b[2], ca[1:0] + b[1:0]};
      if (qo || (chop && b > 3))
      begin
        check(dqOeN, 1'b1);
        check(dqsOeN, 1'b1);
      end
      else
      begin
        check(dqOeN, 1'b0);
        check(dqsOeN, 1'b0);
        check(dqOut, 16'h0a00 + {burst, c});
        check(dqsOut, !b[0]);
      end
    end
    burst = burst + 13'h0001;
  endtask

  // Writes once and times the internal write from the command edge.
  task automatic wr(input logic [2:0] ca, input logic chop, input int t,
    input logic [7:0] m);
    int n;
    cmd(1'b1, 1'b0, 1'b0, 3'h0, {3'h0, ~chop, 9'h000, ca});
    n = 1;
    while (intWrite !== 1'b1 && n < 40)
    begin
      @(posedge mclk);
      #1;
      if (n == 2)
      begin
        check(termSelWr, tw);
        check(termNeedsDll, 1'b0);
      end
      n++;
    end
    check(n[15:0], t[15:0] + 16'h0001);
    check(wrBeatMask, m);
    if (n >= 40)
      finalReport();
  endtask

  // Field decodes, the self-clearing DLL reset and the exit choice.
  task automatic fieldScenario();
    int hits;
    logic [4:0] wrt [8] = '{5'h10, 5'h05, 5'h06, 5'h07, 5'h08, 5'h0a,
      5'h0c, 5'h0e};
    for (int i = 0; i < 8; i++)
    begin
      mrs(3'h0, {4'h0, i[2:0], 9'h000});
      check(wrRecovery, wrt[i]);
      mrs(3'h0, {9'h000, i[2:0], 4'h0});
      check(casLatency, 5'h04 + i[4:0]);
    end
    mrs(3'h0, 16'h1104);
    check(testMode, 1'b0);
    hits = 0;
    for (int k = 0; k < 4; k++)
    begin
      hits += (dllResetPulse === 1'b1);
      @(posedge mclk);
      #1;
    end
    check(hits[15:0], 16'h0001);
    check(casLatency, 5'h0c);
    check(slowExit, 1'b0);
    prechargePd = 1'b1;
    #1;
    check(dllOn, 1'b1);
    mrs(3'h0, 16'h0000);
    check(dllOn, 1'b0);
    prechargePd = 1'b0;
    mrs(3'h1, 16'h008e);
    check(drvImpedance, 2'h1);
    check(rttNom, 3'h1);
    check(addLatency, 5'h03);
    check(writeLevel, 1'b1);
    check(readLatency, 5'h07);
    mrs(3'h1, 16'h0020);
    check(drvImpedance, 2'h2);
  endtask

  // Back-to-back reads in every order, chop and output-off modes.
  task automatic readScenario();
    repeat (DLL_LOCK_CYCLES) @(posedge mclk);
    mrs(3'h1, 16'h0010);
    mrs(3'h0, 16'h0010);
    rl = 8;
    rd(3'h1, 1'b0, 1'b0, 1'b0);
    rd(3'h7, 1'b0, 1'b0, 1'b0);
    mrs(3'h0, 16'h0018);
    rd(3'h5, 1'b0, 1'b1, 1'b0);
    mrs(3'h0, 16'h0011);
    rd(3'h6, 1'b1, 1'b0, 1'b0);
    rd(3'h3, 1'b0, 1'b0, 1'b0);
    mrs(3'h0, 16'h001a);
    rd(3'h3, 1'b1, 1'b1, 1'b0);
    mrs(3'h1, 16'h1010);
    qo = 1'b1;
    rd(3'h2, 1'b0, 1'b0, 1'b0);
    qo = 1'b0;
  endtask

  // Drains the buffer with the source stalled, then lets it resume.
  task automatic stallScenario();
    mrs(3'h1, 16'h0010);
    mrs(3'h0, 16'h0010);
    repeat (20) @(posedge mclk);
    #1;
    check(arrReady, 1'b0);
    pause = 1'b1;
    rd(3'h0, 1'b0, 1'b0, 1'b0);
    rd(3'h4, 1'b0, 1'b0, 1'b0);
    rd(3'h6, 1'b0, 1'b0, 1'b0);
    fork
      rd(3'h2, 1'b0, 1'b0, 1'b1);
      begin
        repeat (20) @(posedge mclk);
        #1;
        pause = 1'b0;
      end
    join
    check(16'(waitN > 20), 16'h0001);
  endtask

  // Write timing, beat masks, termination and the self-refresh DLL.
  task automatic writeScenario();
    mrs(3'h1, 16'h0000);
    mrs(3'h2, 16'h0000);
    mrs(3'h0, 16'h0010);
    wr(3'h3, 1'b0, 9, 8'hff);
    mrs(3'h0, 16'h0012);
    wr(3'h5, 1'b0, 7, 8'hf0);
    wr(3'h2, 1'b0, 7, 8'h0f);
    mrs(3'h0, 16'h0011);
    wr(3'h4, 1'b1, 9, 8'hf0);
    mrs(3'h1, 16'h0001);
    check(dllOn, 1'b0);
    mrs(3'h1, 16'h0000);
    mrs(3'h2, 16'h0200);
    check(rttWr, 2'h1);
    odt = 1'b1;
    tw = 1'b1;
    wr(3'h7, 1'b0, 9, 8'hff);
    odt = 1'b0;
    tw = 1'b0;
    mrs(3'h2, 16'h0000);
    selfRefresh = 1'b1;
    #1;
    check(dllOn, 1'b0);
    @(posedge mclk);
    #1;
    selfRefresh = 1'b0;
    #1;
    check(dllOn, 1'b1);
  endtask

  // Main sequence: reset, then each scenario in turn.
  initial
  begin
    repeat (20) @(posedge mclk);
    #1;
    check(dqOeN, 1'b1);
    resetn = 1'b1;
    repeat (30) @(posedge mclk);
    #1;
    check(casLatency, 5'h04);
    check(readLatency, 5'h04);
    check(arrReady, 1'b0);
    fieldScenario();
    readScenario();
    stallScenario();
    writeScenario();
    finalReport();
  end
endmodule
`default_nettype wire

// file: verification/dmr_array_model.sv
// Array word source that feeds the read buffer, with a pause input.
`default_nettype none
module dmr_array_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Stall request from the bench
  input wire logic pause,
  // Word stream towards the buffer
  output logic arrValid,
  output logic [15:0] arrData,
  input wire logic arrReady
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] idx;
  // Counts the words taken, so word n always carries a known value.
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
      idx <= 16'h0000;
    else if (arrValid && arrReady)
      idx <= idx + 16'h0001;
  // An idle line shows the inverse, so stale data cannot pass for a word.
  assign arrValid = resetn && !pause;
  assign arrData = arrValid ? 16'h0a00 + idx : ~(16'h0a00 + idx);
endmodule
`default_nettype wire
